/* verilog/pmw_pkg.sv */
// Package for the single-word write path of a PCI bus master.
// Assumes a 32-bit PCI bus, a 32-bit local bus and one 100 MHz clock.
package pmw_pkg;

  // Bus widths.
  localparam int AD_W    = 32;
  localparam int CBE_W   = 4;
  localparam int BURST_W = 8;
  localparam int STATE_W = 4;
  localparam int TERM_W  = 3;

  // Visible transfer state codes on the local side.
  localparam logic [STATE_W-1:0] XS_IDLE      = 4'h0;
  localparam logic [STATE_W-1:0] XS_ADDR_LOAD = 4'h1;
  localparam logic [STATE_W-1:0] XS_BUS_XACT  = 4'h2;
  localparam logic [STATE_W-1:0] XS_BUS_TERM  = 4'h3;

  // Termination reasons.
  localparam logic [TERM_W-1:0] TERM_NONE   = 3'h0;
  localparam logic [TERM_W-1:0] TERM_NORMAL = 3'h1;

  // Wishbone register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DONE   = 8'h08;

  // Control field positions and reset value.
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

  // Status field positions.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_TERM_LSB  = 4;
  localparam int ST_BUSY_BIT  = 7;
  localparam int ST_CNT_LSB   = 8;

  // Sequencer states, one-hot.
  typedef enum logic [8:0] {
    SQ_IDLE  = 9'h001,
    SQ_LOAD  = 9'h002,
    SQ_ADDR  = 9'h004,
    SQ_WAITD = 9'h008,
    SQ_CAPT  = 9'h010,
    SQ_DRIVE = 9'h020,
    SQ_PHASE = 9'h040,
    SQ_TURN  = 9'h080,
    SQ_REL   = 9'h100
  } pmw_seq_t;

endpackage

/* verilog/pmw_top.sv */
// Single-word PCI write master with a classic Wishbone register slave.
// Assumes the local master shares CLK; PCI inputs are synchronised here,
// so every PCI reaction lags the pins by two extra clocks.
//
// Functional notes
// (R1) Local master raises request with address, command and burst length together.
// (R2) A seen local request raises the PCI bus request.
// (R3) With grant and an idle bus, local grant is given.
// (R4) Request and grant seen last cycle: go Address Loading, latch address fields.
// (R5) Local master drops its request after Address Loading unless it wants more.
// (R6) After Address Loading with grant: assert FRAME#, drive address and command.
// (R7) Burst counter loads the latched burst length in the address phase.
// (R8) Local master presents data and byte enables in the address phase.
// (R9) Transfer strobe is given in the address phase when ready was seen.
// (R10) Local master holds ready off until it can supply write data.
// (R11) A fast target claims with DEVSEL# and TRDY# after the address.
// (R12) Bus request drops once FRAME# was driven and local request was off.
// (R13) Local master advances its address counter after the transfer strobe.
// (R14) The captured word and byte enables go onto AD and C/BE.
// (R15) Local grant follows PCI grant back off.
// (R16) IRDY# asserts as FRAME# deasserts; phase ends on IRDY# and TRDY#.
// (R17) Then release bus, clear IRDY#, count to zero, terminate normally.
// (R18) Target drops DEVSEL# and TRDY# in the turnaround cycle.
// (R19) One cycle later IRDY# and PAR stop being driven.
// (R20) Transfer states and termination reason use fixed distinct codes.
`timescale 1ns/100ps
module pmw_top
  import pmw_pkg::*;
(
  // Clock and reset.
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // Local master side.
  input  wire logic               LOCAL_REQ_WORD_N,
  input  wire logic [AD_W-1:0]    LOCAL_AD_IN,
  input  wire logic [CBE_W-1:0]   LOCAL_CMD_BYTEEN_IN,
  input  wire logic [BURST_W-1:0] LOCAL_BURST_LEN,
  input  wire logic               LOCAL_READY_IN_N,
  output logic                    LOCAL_GRANT_OUT_N,
  output logic                    LOCAL_XFER_STROBE_N,
  output logic [STATE_W-1:0]      LOCAL_XFER_STATE,
  output logic [TERM_W-1:0]       TERMINATION_REASON,
  output logic [BURST_W-1:0]      BURST_REMAINING_COUNT,
  // PCI arbitration.
  output logic                    REQ_N,
  input  wire logic               GNT_N,
  // PCI control, shared lines split into in, out and enable.
  input  wire logic               FRAME_N_I,
  output logic                    FRAME_N_O,
  output logic                    FRAME_OE_N,
  input  wire logic               IRDY_N_I,
  output logic                    IRDY_N_O,
  output logic                    IRDY_OE_N,
  input  wire logic               TRDY_N,
  input  wire logic               DEVSEL_N,
  // PCI address, data, byte enables and parity.
  output logic [AD_W-1:0]         AD_O,
  output logic                    AD_OE_N,
  output logic [CBE_W-1:0]        CBE_O,
  output logic                    CBE_OE_N,
  output logic                    PAR_O,
  output logic                    PAR_OE_N,
  // Wishbone slave.
  input  wire logic               WB_CYC_I,
  input  wire logic               WB_STB_I,
  input  wire logic               WB_WE_I,
  input  wire logic [7:0]         WB_ADR_I,
  input  wire logic [3:0]         WB_SEL_I,
  input  wire logic [31:0]        WB_DAT_I,
  output logic [31:0]             WB_DAT_O,
  output logic                    WB_ACK_O
);

  // PCI pins pass two flip-flops before use; order is gnt, trdy, devsel, frame, irdy.
  logic [4:0] sync_a;
  logic [4:0] sync_b;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_a <= 5'h1f;
      sync_b <= 5'h1f;
    end else begin
      sync_a <= {GNT_N, TRDY_N, DEVSEL_N, FRAME_N_I, IRDY_N_I};
      sync_b <= sync_a;
    end
  end

  // Active-high views of the synchronised pins.
  wire gnt      = ~sync_b[4];
  wire trdy     = ~sync_b[3];
  wire bus_idle = sync_b[1] & sync_b[0];

  // Sequencer, latched request fields and captured write word.
  pmw_seq_t             seq;
  pmw_seq_t             next_seq;
  logic                 req_q;
  logic                 gnt_q;
  logic                 rdy_q;
  logic [AD_W-1:0]      addr_lat;
  logic [CBE_W-1:0]     cmd_lat;
  logic [BURST_W-1:0]   len_lat;
  logic [AD_W-1:0]      data_lat;
  logic [CBE_W-1:0]     be_lat;
  logic [31:0]          ctrl;
  logic [15:0]          done_cnt;

  // Local inputs share the clock, so they are registered once only for the
  // "seen in the previous cycle" conditions.
  wire req_now = ~LOCAL_REQ_WORD_N & ctrl[CTRL_EN_BIT];
  wire rdy_now = ~LOCAL_READY_IN_N;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      req_q   <= 1'b0;
      gnt_q   <= 1'b0;
      rdy_q   <= 1'b0;
    end else begin
      req_q   <= req_now;
      gnt_q   <= gnt;
      rdy_q   <= rdy_now;
    end
  end

  // Next-state decode.
  wire start_load = seq == SQ_IDLE && req_q && gnt_q && bus_idle;
  wire phase_done = seq == SQ_PHASE && trdy;

  always_comb begin
    next_seq = seq;
    case (seq)
      SQ_IDLE:  if (start_load) next_seq = SQ_LOAD;                    // R4
      SQ_LOAD:  if (gnt) next_seq = SQ_ADDR;                           // R6
                else next_seq = SQ_IDLE;
      SQ_ADDR:  next_seq = LOCAL_XFER_STROBE_N ? SQ_WAITD : SQ_DRIVE;
      SQ_WAITD: if (rdy_now) next_seq = SQ_CAPT;
      SQ_CAPT:  next_seq = SQ_DRIVE;
      SQ_DRIVE: next_seq = SQ_PHASE;
      SQ_PHASE: if (phase_done) next_seq = SQ_TURN;                    // R16
      SQ_TURN:  next_seq = SQ_REL;
      SQ_REL:   next_seq = SQ_IDLE;
      default:  next_seq = SQ_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) seq <= SQ_IDLE;
    else seq <= next_seq;
  end

  // Latch address, command and length at entry to Address Loading.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      addr_lat <= 32'h0000_0000;
      cmd_lat  <= 4'h0;
      len_lat  <= 8'h00;
    end else if (start_load) begin
      addr_lat <= LOCAL_AD_IN;                                          // R4
      cmd_lat  <= LOCAL_CMD_BYTEEN_IN;
      len_lat  <= LOCAL_BURST_LEN;
    end
  end

  // The word is taken while the strobe is shown; the master holds it there.
  wire take_data = (seq == SQ_ADDR || seq == SQ_CAPT) && !LOCAL_XFER_STROBE_N;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      data_lat <= 32'h0000_0000;
      be_lat   <= 4'h0;
    end else if (take_data) begin
      data_lat <= LOCAL_AD_IN;                                          // R9
      be_lat   <= LOCAL_CMD_BYTEEN_IN;
    end
  end

  // FRAME# driven low by this block. Both it and the request are looked at
  // directly, since a second register stage would hold REQ# a cycle too long.
  wire frame_on = ~FRAME_N_O & ~FRAME_OE_N;

  // Arbitration request and local grant.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      REQ_N             <= 1'b1;
      LOCAL_GRANT_OUT_N <= 1'b1;
    end else begin
      if (frame_on && !req_now) REQ_N <= 1'b1;                          // R12
      else if (req_now && seq == SQ_IDLE) REQ_N <= 1'b0;                // R2
      LOCAL_GRANT_OUT_N <= ~(gnt && (bus_idle || seq != SQ_IDLE));      // R3 R15
    end
  end

  // Local strobe, visible state, termination reason and burst counter.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      LOCAL_XFER_STROBE_N   <= 1'b1;
      LOCAL_XFER_STATE      <= XS_IDLE;
      TERMINATION_REASON    <= TERM_NONE;
      BURST_REMAINING_COUNT <= 8'h00;
    end else begin
      // Strobe lasts exactly one cycle: the address phase or the late capture.
      LOCAL_XFER_STROBE_N <= ~((seq == SQ_LOAD && gnt && rdy_q) ||
                               (seq == SQ_WAITD && rdy_now));           // R9
      case (next_seq)
        SQ_LOAD: LOCAL_XFER_STATE <= XS_ADDR_LOAD;                      // R4 R20
        SQ_ADDR: LOCAL_XFER_STATE <= XS_BUS_XACT;                       // R6 R20
        SQ_TURN: LOCAL_XFER_STATE <= XS_BUS_TERM;                       // R17 R20
        SQ_IDLE: LOCAL_XFER_STATE <= XS_IDLE;
        default: LOCAL_XFER_STATE <= LOCAL_XFER_STATE;
      endcase
      if (next_seq == SQ_LOAD) TERMINATION_REASON <= TERM_NONE;
      else if (phase_done) TERMINATION_REASON <= TERM_NORMAL;           // R17
      if (seq == SQ_LOAD && gnt) BURST_REMAINING_COUNT <= len_lat;      // R7
      else if (phase_done && BURST_REMAINING_COUNT != 8'h00) begin
        BURST_REMAINING_COUNT <= BURST_REMAINING_COUNT - 8'h01;         // R17
      end
    end
  end

  // PCI drive. FRAME# is parked high through the data phase and IRDY# for one cycle before release.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      FRAME_N_O  <= 1'b1;
      FRAME_OE_N <= 1'b1;
      IRDY_N_O   <= 1'b1;
      IRDY_OE_N  <= 1'b1;
      AD_O       <= 32'h0000_0000;
      AD_OE_N    <= 1'b1;
      CBE_O      <= 4'h0;
      CBE_OE_N   <= 1'b1;
    end else begin
      case (next_seq)
        SQ_ADDR: begin
          FRAME_N_O  <= 1'b0;                                           // R6
          FRAME_OE_N <= 1'b0;
          IRDY_N_O   <= 1'b1;
          IRDY_OE_N  <= 1'b0;
          AD_O       <= addr_lat;
          AD_OE_N    <= 1'b0;
          CBE_O      <= cmd_lat;
          CBE_OE_N   <= 1'b0;
        end
        SQ_DRIVE: begin
          AD_O  <= data_lat;                                            // R14
          CBE_O <= be_lat;
        end
        SQ_PHASE: begin
          FRAME_N_O <= 1'b1;                                            // R16
          IRDY_N_O  <= 1'b0;
        end
        SQ_TURN: begin
          FRAME_OE_N <= 1'b1;                                           // R17
          IRDY_N_O   <= 1'b1;
          AD_OE_N    <= 1'b1;
          CBE_OE_N   <= 1'b1;
        end
        SQ_REL: begin
          IRDY_OE_N <= 1'b1;                                            // R19
        end
        default: begin
          FRAME_N_O <= FRAME_N_O;
        end
      endcase
      // The data latch fills on this same edge, so the word bypasses it and
      // goes straight from the local inputs onto the bus.
      if (take_data) begin
        AD_O  <= LOCAL_AD_IN;                                           // R14
        CBE_O <= LOCAL_CMD_BYTEEN_IN;
      end
    end
  end

  // Even parity trails AD and C/BE by one clock and is released one clock
  // after them, which lands its release in the idle cycle after turnaround.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PAR_O    <= 1'b0;
      PAR_OE_N <= 1'b1;
    end else begin
      PAR_O    <= ^{AD_O, CBE_O};
      PAR_OE_N <= AD_OE_N;                                              // R19
    end
  end

  // Count of completed writes, readable by software.
  always_ff @(posedge CLK) begin
    if (!RST_N) done_cnt <= 16'h0000;
    else if (phase_done) done_cnt <= done_cnt + 16'h0001;
  end

  // Wishbone decode.
  wire       wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire       hit_ctrl = WB_ADR_I == REG_CTRL;
  wire       hit_stat = WB_ADR_I == REG_STATUS;
  wire       hit_done = WB_ADR_I == REG_DONE;
  wire       busy     = seq != SQ_IDLE;
  wire [31:0] stat_word = {16'h0000, BURST_REMAINING_COUNT, busy, TERMINATION_REASON,
                           LOCAL_XFER_STATE};
  wire [31:0] rd_word = hit_ctrl ? ctrl :
                        hit_stat ? stat_word :
                        hit_done ? {16'h0000, done_cnt} : 32'h0000_0000;

  // Byte-lane merge for control writes.
  wire [31:0] wr_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                         {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [31:0] ctrl_wr = (ctrl & ~wr_mask) | (WB_DAT_I & wr_mask);

  // Every access, mapped or not, is acknowledged one cycle after the strobe;
  // unmapped reads return zero and unmapped writes are dropped.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      ctrl     <= CTRL_RESET;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_req && !WB_WE_I) WB_DAT_O <= rd_word;
      if (wb_req && WB_WE_I && hit_ctrl) ctrl <= ctrl_wr;
    end
  end

endmodule

/* verif/pmw_props.sv */
// Checker for the single-word PCI write master, bound to its top.
// Assumes one clock and the synchronous active-low reset of the top.
`timescale 1ns/100ps
module pmw_props
  import pmw_pkg::*;
(
  // Clock, reset and local side.
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic               LOCAL_REQ_WORD_N,
  input wire logic [AD_W-1:0]    LOCAL_AD_IN,
  input wire logic [CBE_W-1:0]   LOCAL_CMD_BYTEEN_IN,
  input wire logic [BURST_W-1:0] LOCAL_BURST_LEN,
  input wire logic               LOCAL_READY_IN_N,
  input wire logic               LOCAL_GRANT_OUT_N,
  input wire logic               LOCAL_XFER_STROBE_N,
  input wire logic [STATE_W-1:0] LOCAL_XFER_STATE,
  input wire logic [TERM_W-1:0]  TERMINATION_REASON,
  input wire logic [BURST_W-1:0] BURST_REMAINING_COUNT,
  // PCI side.
  input wire logic               REQ_N,
  input wire logic               GNT_N,
  input wire logic               FRAME_N_O,
  input wire logic               FRAME_OE_N,
  input wire logic               IRDY_N_O,
  input wire logic               IRDY_OE_N,
  input wire logic [AD_W-1:0]    AD_O,
  input wire logic               AD_OE_N,
  input wire logic [CBE_W-1:0]   CBE_O,
  input wire logic               CBE_OE_N,
  input wire logic               PAR_OE_N
);
  logic [AD_W-1:0]    adr_q;
  logic [CBE_W-1:0]   cmd_q;
  logic [BURST_W-1:0] len_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Follows the offered fields while idle, so they freeze on entry to loading.
  always_ff @(posedge CLK) begin
    if (LOCAL_XFER_STATE == XS_IDLE) begin
      adr_q <= LOCAL_AD_IN;
      cmd_q <= LOCAL_CMD_BYTEEN_IN;
      len_q <= LOCAL_BURST_LEN;
    end
  end

  // State entries, seen on the edge where the code changes.
  sequence s_xact;
    $changed(LOCAL_XFER_STATE) && LOCAL_XFER_STATE == XS_BUS_XACT;
  endsequence
  sequence s_term;
    $changed(LOCAL_XFER_STATE) && LOCAL_XFER_STATE == XS_BUS_TERM;
  endsequence

  req_ask_a: assert property (
    $fell(REQ_N) |-> $past(!LOCAL_REQ_WORD_N)) else $error("bus request raised unasked");
  grant_give_a: assert property (
    $fell(LOCAL_GRANT_OUT_N) |-> $past(!GNT_N, 2) && FRAME_OE_N)
    else $error("local grant without bus grant");
  grant_follow_a: assert property (
    $rose(GNT_N) |-> ##[1:4] LOCAL_GRANT_OUT_N) else $error("local grant kept after bus grant");
  load_entry_a: assert property (
    $changed(LOCAL_XFER_STATE) && LOCAL_XFER_STATE == XS_ADDR_LOAD
    |-> $past(!LOCAL_REQ_WORD_N) && $past(!GNT_N, 2)) else $error("loading without request");
  addr_phase_a: assert property (
    s_xact |-> $past(LOCAL_XFER_STATE) == XS_ADDR_LOAD && !FRAME_N_O && !FRAME_OE_N
    && AD_O == adr_q && CBE_O == cmd_q && BURST_REMAINING_COUNT == len_q
    && !AD_OE_N) else $error("address phase wrong");
  strobe_ready_a: assert property (
    !LOCAL_XFER_STROBE_N |-> $past(!LOCAL_READY_IN_N) ##1 LOCAL_XFER_STROBE_N)
    else $error("strobe without ready or too long");
  data_drive_a: assert property (
    !LOCAL_XFER_STROBE_N |=> AD_O == $past(LOCAL_AD_IN) && !AD_OE_N
    && CBE_O == $past(LOCAL_CMD_BYTEEN_IN)) else $error("data word not driven");
  irdy_frame_a: assert property (
    $fell(IRDY_N_O) |-> $rose(FRAME_N_O) && !IRDY_OE_N && $stable(AD_O))
    else $error("ready and frame out of step");
  req_drop_a: assert property (
    !FRAME_OE_N && !FRAME_N_O && LOCAL_REQ_WORD_N |=> REQ_N)
    else $error("bus request not dropped");
  term_normal_a: assert property (
    s_term |-> TERMINATION_REASON == TERM_NORMAL && FRAME_OE_N && AD_OE_N && CBE_OE_N
    && IRDY_N_O && BURST_REMAINING_COUNT == BURST_W'($past(BURST_REMAINING_COUNT) - 1))
    else $error("termination wrong");
  last_release_a: assert property (
    s_term |=> IRDY_OE_N && PAR_OE_N) else $error("ready or parity still driven");
endmodule

bind pmw_top pmw_props chk_u (.*);

/* verif/pmw_pci_model.sv */
// Far side of the write path: a PCI arbiter and one fast-decode target.
// Assumes FRAME# and IRDY# arrive resolved with their pull-ups.
`timescale 1ns/100ps
module pmw_pci_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bus lines seen and driven.
  input  wire logic       req_n,
  input  wire logic       frame_n,
  input  wire logic       irdy_n,
  input  wire logic [1:0] wait_cyc,
  output logic            gnt_n,
  output logic            trdy_n,
  output logic            devsel_n
);
  logic [1:0] cnt;

  // Grants whoever asks; the target may insert wait states before it is ready.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gnt_n    <= 1'b1;
      trdy_n   <= 1'b1;
      devsel_n <= 1'b1;
      cnt      <= 2'h0;
    end else begin
      gnt_n <= req_n;
      if (!trdy_n && !irdy_n) begin
        trdy_n   <= 1'b1;
        devsel_n <= 1'b1;
      end else if (!devsel_n) begin
        cnt <= cnt + 2'h1;
        if (cnt == wait_cyc) trdy_n <= 1'b0;
      end else if (!frame_n) begin
        devsel_n <= 1'b0;
        trdy_n   <= (wait_cyc != 2'h0);
        cnt      <= 2'h1;
      end
    end
  end
endmodule

/* verif/tb.sv */
// Self-checking bench for the single-word PCI write master.
// The local side and Wishbone are driven here; the model plays arbiter and target.
`timescale 1ns/100ps
module tb;
  import pmw_pkg::*;
  logic               CLK, RST_N, LOCAL_REQ_WORD_N, LOCAL_READY_IN_N;
  logic               GNT_N, TRDY_N, DEVSEL_N, LOCAL_GRANT_OUT_N, LOCAL_XFER_STROBE_N;
  logic               REQ_N, FRAME_N_O, FRAME_OE_N, IRDY_N_O, IRDY_OE_N;
  logic               AD_OE_N, CBE_OE_N, PAR_O, PAR_OE_N;
  logic [AD_W-1:0]    LOCAL_AD_IN, AD_O;
  logic [CBE_W-1:0]   LOCAL_CMD_BYTEEN_IN, CBE_O;
  logic [BURST_W-1:0] LOCAL_BURST_LEN, BURST_REMAINING_COUNT;
  logic [STATE_W-1:0] LOCAL_XFER_STATE;
  logic [TERM_W-1:0]  TERMINATION_REASON;
  logic               WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0]         WB_ADR_I;
  logic [3:0]         WB_SEL_I;
  logic [31:0]        WB_DAT_I, WB_DAT_O;
  logic [1:0]         wait_cyc;
  int                 err_count, n_compared, n_done;
  // Shared control lines rest high through their pull-ups when nobody drives.
  wire                FRAME_N_I = FRAME_OE_N ? 1'b1 : FRAME_N_O;
  wire                IRDY_N_I = IRDY_OE_N ? 1'b1 : IRDY_N_O;

  pmw_top dut_u (.*);
  pmw_pci_model far_u (.clk(CLK), .rst_n(RST_N), .req_n(REQ_N), .frame_n(FRAME_N_I),
    .irdy_n(IRDY_N_I), .wait_cyc(wait_cyc), .gnt_n(GNT_N), .trdy_n(TRDY_N), .devsel_n(DEVSEL_N));

  // The clock runs free at 100 MHz.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; read data is taken at the acknowledging edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    // Only the watchdog ends a wait for the acknowledge.
    while (WB_ACK_O !== 1'b1) @(posedge CLK);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask

  task automatic wait_st(input logic [STATE_W-1:0] s);
    int n;
    for (n = 0; n < 60 && LOCAL_XFER_STATE !== s; n++) @(negedge CLK);
    chk("state", LOCAL_XFER_STATE, s);
  endtask

  // Idle pins after reset, the enable register and an unmapped read.
  task automatic t_reset();
    logic [31:0] q;
    @(negedge CLK);
    chk("idle_pins", {REQ_N, LOCAL_GRANT_OUT_N, FRAME_OE_N, IRDY_OE_N, AD_OE_N}, 32'h1f);
    wb(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl", q, 32'h1);
    wb(1'b0, 8'h0c, 32'h0, q);
    chk("unmapped", q, 32'h0);
  endtask

  // A request is ignored while the enable bit is clear.
  task automatic t_refuse();
    logic [31:0] q;
    wb(1'b1, REG_CTRL, 32'h0, q);
    @(posedge CLK);
    LOCAL_REQ_WORD_N <= 1'b0;
    repeat (8) @(negedge CLK);
    chk("req_off", REQ_N, 1'b1);
    @(posedge CLK);
    LOCAL_REQ_WORD_N <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h1, q);
  endtask

  // One full single write; late delays ready, wt delays the target.
  task automatic t_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be,
                         input int late, input logic [1:0] wt);
    logic [31:0] q;
    int n;
    @(posedge CLK);
    wait_cyc <= wt;
    LOCAL_REQ_WORD_N <= 1'b0;
    LOCAL_AD_IN <= a;
    LOCAL_CMD_BYTEEN_IN <= 4'h7;
    LOCAL_BURST_LEN <= 8'h01;
    LOCAL_READY_IN_N <= (late != 0);
    wait_st(XS_ADDR_LOAD);
    chk("grant", LOCAL_GRANT_OUT_N, 1'b0);
    @(posedge CLK);
    LOCAL_REQ_WORD_N <= 1'b1;
    LOCAL_AD_IN <= d;
    LOCAL_CMD_BYTEEN_IN <= be;
    @(negedge CLK);
    chk("xact", LOCAL_XFER_STATE, XS_BUS_XACT);
    chk("addr", AD_O, a);
    chk("cmd", CBE_O, 4'h7);
    chk("count", BURST_REMAINING_COUNT, 8'h01);
    chk("strobe_at_addr", LOCAL_XFER_STROBE_N, late != 0);
    if (late != 0) begin
      repeat (late) @(negedge CLK);
      chk("held_off", LOCAL_XFER_STROBE_N, 1'b1);
      @(posedge CLK);
      LOCAL_READY_IN_N <= 1'b0;
    end
    for (n = 0; n < 20 && LOCAL_XFER_STROBE_N !== 1'b0; n++) @(negedge CLK);
    chk("strobe", LOCAL_XFER_STROBE_N, 1'b0);
    @(negedge CLK);
    chk("data", AD_O, d);
    chk("byte_en", CBE_O, be);
    @(posedge CLK);
    LOCAL_READY_IN_N <= 1'b1;
    LOCAL_AD_IN <= d + 32'h4;
    for (n = 0; n < 20 && IRDY_N_O !== 1'b0; n++) @(negedge CLK);
    chk("frame_end", {FRAME_N_O, IRDY_N_O}, 2'b10);
    chk("held_data", AD_O, d);
    chk("parity", PAR_O, ^{d, be});
    wait_st(XS_BUS_TERM);
    chk("reason", TERMINATION_REASON, TERM_NORMAL);
    chk("count_end", BURST_REMAINING_COUNT, 8'h00);
    chk("released", {FRAME_OE_N, AD_OE_N, CBE_OE_N, IRDY_N_O}, 4'hf);
    @(negedge CLK);
    chk("let_go", {IRDY_OE_N, PAR_OE_N}, 2'h3);
    repeat (6) @(negedge CLK);
    chk("req_grant", {REQ_N, LOCAL_GRANT_OUT_N}, 2'h3);
    n_done++;
    wb(1'b0, REG_DONE, 32'h0, q);
    chk("done", q, n_done);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("status", q, {24'h000000, 1'b0, TERM_NORMAL, XS_IDLE});
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hung handshake is cut short long after the scenarios should be over.
  initial begin
    #100000;
    err_count++;
    test_done();
  end

  initial begin
    RST_N = 1'b0;
    LOCAL_REQ_WORD_N = 1'b1;
    LOCAL_READY_IN_N = 1'b1;
    LOCAL_AD_IN = '0;
    LOCAL_CMD_BYTEEN_IN = '0;
    LOCAL_BURST_LEN = '0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} = '0;
    WB_SEL_I = 4'hf;
    wait_cyc = 2'h0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_refuse();
    t_write(32'h0000_1000, 32'hcafe_0001, 4'h0, 0, 2'h0);
    t_write(32'h0000_2004, 32'h1234_5678, 4'h5, 3, 2'h2);
    test_done();
  end
endmodule
